/* hw/ofr_pkg.sv */
/*
  constants for the output format and timing register bank: offsets, field
  positions, reset values and codes.
  assumes an 8-bit register address space reached from the serial control port.
*/
package ofr_pkg;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned SAMPLE_W = 12;

  localparam logic [7:0] ADDR_OUT_FORMAT = 8'h14;
  localparam logic [7:0] ADDR_DRIVE      = 8'h15;
  localparam logic [7:0] ADDR_PHASE      = 8'h16;
  localparam logic [7:0] ADDR_FINE_DELAY = 8'h17;
  localparam logic [7:0] ADDR_PATT1_LO   = 8'h19;
  localparam logic [7:0] ADDR_PATT1_HI   = 8'h1A;
  localparam logic [7:0] ADDR_TRANSFER   = 8'hFF;

  localparam logic [7:0] RST_OUT_FORMAT = 8'h00;
  localparam logic [7:0] RST_DRIVE      = 8'h22;
  localparam logic [7:0] RST_PHASE      = 8'h00;
  localparam logic [7:0] RST_FINE_DELAY = 8'h00;
  localparam logic [7:0] RST_PATT1_LO   = 8'h00;
  localparam logic [7:0] RST_PATT1_HI   = 8'h00;

  // output format register fields
  localparam int unsigned FMT_LSB     = 0;
  localparam int unsigned INVERT_BIT  = 2;
  localparam int unsigned DISABLE_BIT = 4;
  localparam logic [1:0] FMT_OFFSET_BIN = 2'h0;
  localparam logic [1:0] FMT_TWOS       = 2'h1;
  localparam logic [1:0] FMT_GRAY       = 2'h2;

  // drive register fields, two bits each
  localparam int unsigned DRV_CLK_HI_LSB  = 6;
  localparam int unsigned DRV_CLK_LO_LSB  = 4;
  localparam int unsigned DRV_DATA_HI_LSB = 2;
  localparam int unsigned DRV_DATA_LO_LSB = 0;

  // phase register fields
  localparam int unsigned PHASE_LSB    = 0;
  localparam int unsigned POLARITY_BIT = 7;

  // fine delay register fields
  localparam int unsigned DELAY_LSB       = 0;
  localparam int unsigned DATA_DLY_EN_BIT = 5;
  localparam int unsigned CLK_DLY_EN_BIT  = 7;
  localparam int unsigned DELAY_STEP_PS   = 560;
  localparam int unsigned DELAY_MAX_PS    = 4480;

  localparam int unsigned TRANSFER_BIT = 0;

  // test mode code that puts the user pattern on the pins
  localparam logic [3:0] TEST_USER_INPUT = 4'h8;

  // divider ratio codes
  localparam logic [2:0] DIV_BY_1 = 3'h0;

  localparam int unsigned NUM_REGS = 6;
endpackage

/* hw/ofr_cfg_if.sv */
/*
  carries the active (transferred) configuration bytes from the register
  module to the output formatter.
  assumes both ends run on the same sampling clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface ofr_cfg_if;
  logic [7:0] out_format;
  logic [7:0] drive;
  logic [7:0] phase;
  logic [7:0] fine_delay;
  logic [15:0] pattern1;

  modport regs_mp (output out_format, output drive, output phase, output fine_delay, output pattern1);
  modport core_mp (input out_format, input drive, input phase, input fine_delay, input pattern1);
endinterface
`default_nettype wire

/* hw/ofr_reg_bank.sv */
/*
  master and active register copies for the output format bank, with the
  transfer register that copies master into active.
  assumes write and read strobes are one-cycle pulses on the sampling clock.
*/
`timescale 1ns/1ns
`default_nettype none
module ofr_reg_bank (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output var  logic [7:0] reg_rdata_o,
  output var  logic       reg_rvalid_o,
  ofr_cfg_if.regs_mp      cfg
);
  localparam logic [2:0] NO_SLOT = 3'h7;

  function automatic logic [2:0] addr_slot(input logic [7:0] a);
    if (a == ofr_pkg::ADDR_OUT_FORMAT)
      addr_slot = 3'h0;
    else if (a == ofr_pkg::ADDR_DRIVE)
      addr_slot = 3'h1;
    else if (a == ofr_pkg::ADDR_PHASE)
      addr_slot = 3'h2;
    else if (a == ofr_pkg::ADDR_FINE_DELAY)
      addr_slot = 3'h3;
    else if (a == ofr_pkg::ADDR_PATT1_LO)
      addr_slot = 3'h4;
    else if (a == ofr_pkg::ADDR_PATT1_HI)
      addr_slot = 3'h5;
    else
      addr_slot = NO_SLOT;
  endfunction

  function automatic logic [7:0] reset_value(input int unsigned s);
    case (s)
      0:       reset_value = ofr_pkg::RST_OUT_FORMAT;
      1:       reset_value = ofr_pkg::RST_DRIVE;
      2:       reset_value = ofr_pkg::RST_PHASE;
      3:       reset_value = ofr_pkg::RST_FINE_DELAY;
      4:       reset_value = ofr_pkg::RST_PATT1_LO;
      default: reset_value = ofr_pkg::RST_PATT1_HI;
    endcase
  endfunction

  logic [7:0] mst_r   [ofr_pkg::NUM_REGS];
  logic [7:0] mst_nxt [ofr_pkg::NUM_REGS];
  logic [7:0] act_r   [ofr_pkg::NUM_REGS];
  logic [7:0] act_nxt [ofr_pkg::NUM_REGS];
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       rvalid_r;
  logic       rvalid_nxt;
  logic [2:0] slot;

  always_comb
  begin
    slot       = addr_slot(reg_addr_i);
    mst_nxt    = mst_r;
    act_nxt    = act_r;
    rdata_nxt  = rdata_r;
    rvalid_nxt = reg_rd_i;
    if (reg_wr_i)
    begin
      if (reg_addr_i == ofr_pkg::ADDR_TRANSFER)
      begin
        if (reg_wdata_i[ofr_pkg::TRANSFER_BIT])
          act_nxt = mst_r;
      end
      else if (slot != NO_SLOT)
        mst_nxt[slot] = reg_wdata_i;
    end
    if (reg_rd_i)
      rdata_nxt = (slot != NO_SLOT) ? mst_r[slot] : 8'h00;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      for (int unsigned i = 0; i < ofr_pkg::NUM_REGS; i++)
      begin
        mst_r[i] <= reset_value(i);
        act_r[i] <= reset_value(i);
      end
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end
    else
    begin
      mst_r    <= mst_nxt;
      act_r    <= act_nxt;
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign reg_rdata_o     = rdata_r;
  assign reg_rvalid_o    = rvalid_r;
  assign cfg.out_format  = act_r[0];
  assign cfg.drive       = act_r[1];
  assign cfg.phase       = act_r[2];
  assign cfg.fine_delay  = act_r[3];
  assign cfg.pattern1    = {act_r[5], act_r[4]};

  chk_write_held_back: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (reg_wr_i && reg_addr_i == ofr_pkg::ADDR_PHASE) |=> $stable(cfg.phase))
    else $error("write reached active phase without transfer");

  chk_transfer_copies: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (reg_wr_i && reg_addr_i == ofr_pkg::ADDR_TRANSFER && reg_wdata_i[0])
    |=> cfg.out_format == $past(mst_r[0]) && cfg.pattern1 == {$past(mst_r[5]), $past(mst_r[4])})
    else $error("transfer did not copy master to active");
endmodule
`default_nettype wire

/* hw/ofr_output_top.sv */
/*
  output format and timing stage of the converter: register bank, sample
  word encoding, output disable and invert, data clock phase and polarity,
  fine delay codes, drive settings and user pattern insertion.
  assumes samples arrive offset binary on the sampling clock, and that the
  divider ratio and test mode come from other registers on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module ofr_output_top (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  output var  logic [7:0]  reg_rdata_o,
  output var  logic        reg_rvalid_o,
  input  wire logic [11:0] sample_i,
  input  wire logic [2:0]  clk_div_i,
  input  wire logic [3:0]  test_mode_i,
  output var  logic [11:0] data_o,
  output var  logic        data_oe_o,
  output var  logic        sample_stb_o,
  output var  logic        data_clock_out_o,
  output var  logic [2:0]  clk_dly_code_o,
  output var  logic        clk_dly_en_o,
  output var  logic [2:0]  data_dly_code_o,
  output var  logic        data_dly_en_o,
  output var  logic [1:0]  drive_clk_hi_o,
  output var  logic [1:0]  drive_clk_lo_o,
  output var  logic [1:0]  drive_data_hi_o,
  output var  logic [1:0]  drive_data_lo_o
);
  ofr_cfg_if cfg ();

  ofr_reg_bank u_regs (
    .ref_clk_i    (ref_clk_i),
    .rst_i        (rst_i),
    .reg_wr_i     (reg_wr_i),
    .reg_rd_i     (reg_rd_i),
    .reg_addr_i   (reg_addr_i),
    .reg_wdata_i  (reg_wdata_i),
    .reg_rdata_o  (reg_rdata_o),
    .reg_rvalid_o (reg_rvalid_o),
    .cfg          (cfg.regs_mp)
  );

  // encodes an offset binary sample into the selected word format
  function automatic logic [11:0] encode_word(input logic [11:0] s, input logic [1:0] fmt);
    case (fmt)
      ofr_pkg::FMT_TWOS: encode_word = {~s[11], s[10:0]};
      ofr_pkg::FMT_GRAY: encode_word = s ^ {1'b0, s[11:1]};
      default:           encode_word = s;
    endcase
  endfunction

  logic [1:0]  fmt;
  logic        invert;
  logic        disable_out;
  logic [2:0]  phase_sel;
  logic        polarity;
  logic [2:0]  dly_code;
  logic        user_test;

  assign fmt         = cfg.out_format[ofr_pkg::FMT_LSB +: 2];
  assign invert      = cfg.out_format[ofr_pkg::INVERT_BIT];
  assign disable_out = cfg.out_format[ofr_pkg::DISABLE_BIT];
  assign phase_sel   = cfg.phase[ofr_pkg::PHASE_LSB +: 3];
  assign polarity    = cfg.phase[ofr_pkg::POLARITY_BIT];
  assign dly_code    = cfg.fine_delay[ofr_pkg::DELAY_LSB +: 3];
  assign user_test   = (test_mode_i == ofr_pkg::TEST_USER_INPUT);

  // divider and data clock state
  logic [1:0]  div_cnt_r;
  logic [1:0]  div_cnt_nxt;
  logic        base_clk_r;
  logic        base_clk_nxt;
  logic [7:0]  clk_hist_r;
  logic [7:0]  clk_hist_nxt;
  logic        dco_r;
  logic        dco_nxt;
  logic        stb_r;
  logic        stb_nxt;
  logic [1:0]  div_last;
  logic [1:0]  div_half;

  always_comb
  begin
    div_last     = clk_div_i[1:0];
    div_half     = 2'((3'(div_last) + 3'h1) >> 1);
    div_cnt_nxt  = (div_cnt_r >= div_last) ? 2'h0 : 2'(div_cnt_r + 2'h1);
    // samples latch on the divider wrap, independent of phase selection
    stb_nxt      = (div_cnt_nxt == 2'h0);
    if (clk_div_i == ofr_pkg::DIV_BY_1)
      base_clk_nxt = ~base_clk_r;
    else
      base_clk_nxt = (div_cnt_nxt < div_half);
    clk_hist_nxt = {clk_hist_r[6:0], base_clk_r};
    // tap n of the history is the divider clock n input cycles late
    dco_nxt      = clk_hist_nxt[phase_sel] ^ polarity;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      div_cnt_r  <= 2'h0;
      base_clk_r <= 1'b0;
      clk_hist_r <= 8'h00;
      dco_r      <= 1'b0;
      stb_r      <= 1'b0;
    end
    else
    begin
      div_cnt_r  <= div_cnt_nxt;
      base_clk_r <= base_clk_nxt;
      clk_hist_r <= clk_hist_nxt;
      dco_r      <= dco_nxt;
      stb_r      <= stb_nxt;
    end
  end

  // data word path
  logic [11:0] data_r;
  logic [11:0] data_nxt;
  logic        oe_r;
  logic        oe_nxt;

  always_comb
  begin
    data_nxt = data_r;
    if (stb_nxt)
    begin
      if (user_test)
        data_nxt = cfg.pattern1[15:4];
      else
        data_nxt = encode_word(sample_i, fmt) ^ {12{invert}};
    end
    // enable is low while the pins are driven
    oe_nxt = disable_out;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      data_r <= 12'h000;
      oe_r   <= 1'b0;
    end
    else
    begin
      data_r <= data_nxt;
      oe_r   <= oe_nxt;
    end
  end

  // fine delay and drive settings
  logic [2:0] clk_dly_r;
  logic [2:0] clk_dly_nxt;
  logic       clk_en_r;
  logic       clk_en_nxt;
  logic [2:0] data_dly_r;
  logic [2:0] data_dly_nxt;
  logic       data_en_r;
  logic       data_en_nxt;
  logic [7:0] drive_r;
  logic [7:0] drive_nxt;

  always_comb
  begin
    // each code step is one delay step; zero code is the first step, not bypass
    clk_en_nxt   = cfg.fine_delay[ofr_pkg::CLK_DLY_EN_BIT];
    data_en_nxt  = cfg.fine_delay[ofr_pkg::DATA_DLY_EN_BIT];
    clk_dly_nxt  = clk_en_nxt ? dly_code : 3'h0;
    data_dly_nxt = data_en_nxt ? dly_code : 3'h0;
    drive_nxt    = cfg.drive;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      clk_dly_r  <= 3'h0;
      clk_en_r   <= 1'b0;
      data_dly_r <= 3'h0;
      data_en_r  <= 1'b0;
      drive_r    <= ofr_pkg::RST_DRIVE;
    end
    else
    begin
      clk_dly_r  <= clk_dly_nxt;
      clk_en_r   <= clk_en_nxt;
      data_dly_r <= data_dly_nxt;
      data_en_r  <= data_en_nxt;
      drive_r    <= drive_nxt;
    end
  end

  assign data_o           = data_r;
  assign data_oe_o        = oe_r;
  assign sample_stb_o     = stb_r;
  assign data_clock_out_o = dco_r;
  assign clk_dly_code_o   = clk_dly_r;
  assign clk_dly_en_o     = clk_en_r;
  assign data_dly_code_o  = data_dly_r;
  assign data_dly_en_o    = data_en_r;
  assign drive_clk_hi_o   = drive_r[ofr_pkg::DRV_CLK_HI_LSB +: 2];
  assign drive_clk_lo_o   = drive_r[ofr_pkg::DRV_CLK_LO_LSB +: 2];
  assign drive_data_hi_o  = drive_r[ofr_pkg::DRV_DATA_HI_LSB +: 2];
  assign drive_data_lo_o  = drive_r[ofr_pkg::DRV_DATA_LO_LSB +: 2];

  chk_twos_word: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (stb_nxt && !user_test && fmt == ofr_pkg::FMT_TWOS && !invert)
    |=> data_o == {~$past(sample_i[11]), $past(sample_i[10:0])})
    else $error("two's complement word wrong");

  chk_twos_invert: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (stb_nxt && !user_test && fmt == ofr_pkg::FMT_TWOS && invert)
    |=> data_o == ~{~$past(sample_i[11]), $past(sample_i[10:0])})
    else $error("inverted two's complement word wrong");

  chk_gray_word: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (stb_nxt && !user_test && fmt == ofr_pkg::FMT_GRAY && !invert)
    |=> data_o == ($past(sample_i) ^ ($past(sample_i) >> 1)))
    else $error("gray word wrong");

  chk_gray_invert: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (stb_nxt && !user_test && fmt == ofr_pkg::FMT_GRAY && invert)
    |=> data_o == ~($past(sample_i) ^ ($past(sample_i) >> 1)))
    else $error("inverted gray word wrong");

  chk_offset_invert: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (stb_nxt && !user_test && fmt == ofr_pkg::FMT_OFFSET_BIN)
    |=> data_o == ($past(sample_i) ^ {12{$past(invert)}}))
    else $error("offset binary or invert word wrong");

  chk_word_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !stb_nxt |=> $stable(data_o))
    else $error("data word changed between strobes");

  chk_disable_pins: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $rose(disable_out) |=> data_oe_o ##1 data_oe_o)
    else $error("output enable did not follow disable bit");

  chk_enable_release: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $fell(disable_out) |=> !data_oe_o)
    else $error("pins not driven after disable bit cleared");

  chk_phase_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (phase_sel == 3'h0 && $stable(cfg.phase))
    |-> data_clock_out_o == ($past(base_clk_r) ^ $past(polarity)))
    else $error("undelayed data clock wrong");

  chk_phase_seven: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (phase_sel == 3'h7 && $stable(cfg.phase))
    |-> data_clock_out_o == ($past(base_clk_r, 8) ^ polarity))
    else $error("seven cycle phase delay wrong");

  chk_latch_steady: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ($changed(phase_sel) && $stable(clk_div_i))
    |=> sample_stb_o == ($past(div_cnt_r) == $past(clk_div_i[1:0])))
    else $error("phase change disturbed sample latching");

  chk_clk_delay_gate: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !cfg.fine_delay[ofr_pkg::CLK_DLY_EN_BIT] |=> clk_dly_code_o == 3'h0 && !clk_dly_en_o)
    else $error("clock fine delay applied while disabled");

  chk_clk_delay_on: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cfg.fine_delay[ofr_pkg::CLK_DLY_EN_BIT] |=> clk_dly_en_o && clk_dly_code_o == $past(dly_code))
    else $error("clock fine delay not applied while enabled");

  chk_data_delay_gate: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cfg.fine_delay[ofr_pkg::DATA_DLY_EN_BIT] |=> data_dly_en_o && data_dly_code_o == $past(dly_code))
    else $error("data fine delay not applied while enabled");

  chk_data_delay_off: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !cfg.fine_delay[ofr_pkg::DATA_DLY_EN_BIT] |=> data_dly_code_o == 3'h0 && !data_dly_en_o)
    else $error("data fine delay applied while disabled");

  chk_user_pattern: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (stb_nxt && user_test) |=> data_o == $past(cfg.pattern1[15:4]))
    else $error("user pattern not on data pins");

  chk_drive_follow: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    1'b1 |=> {drive_clk_hi_o, drive_clk_lo_o, drive_data_hi_o, drive_data_lo_o} == $past(cfg.drive))
    else $error("drive settings do not follow register");

  chk_drive_reset: assert property (@(posedge ref_clk_i)
    $fell(rst_i) |-> drive_clk_lo_o == 2'h2 && drive_data_lo_o == 2'h2 && drive_clk_hi_o == 2'h0)
    else $error("drive settings not at reset value");
endmodule
`default_nettype wire

/* verification/ofr_host_model.sv */
/*
  host on the serial control port: register writes and reads as strobe cycles.
  assumes the bench calls its tasks from a single process, clock ref_clk_i.
*/
`timescale 1ns/1ns
`default_nettype none
module ofr_host_model (
  input  wire logic       ref_clk_i,
  output var  logic       reg_wr_o,
  output var  logic       reg_rd_o,
  output var  logic [7:0] reg_addr_o,
  output var  logic [7:0] reg_wdata_o,
  input  wire logic [7:0] reg_rdata_i,
  input  wire logic       reg_rvalid_i
);
  initial
  begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
  end

  // idle address and data are inverted so stale values are never mistaken for live ones
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_wr_o <= 1'b1;
    reg_addr_o <= a;
    reg_wdata_o <= d;
    @(posedge ref_clk_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge ref_clk_i);
    reg_rd_o <= 1'b1;
    reg_addr_o <= a;
    @(posedge ref_clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    #1;
    d = reg_rdata_i;
    v = reg_rvalid_i;
  endtask
endmodule
`default_nettype wire

/* verification/adc_output_format_timing_regs_bench.sv */
/*
  self-checking bench for the output format stage, with a register model.
  assumes ofr_output_top and the host model; clock 10 MHz.
*/
`timescale 1ns/1ns
`default_nettype none
module adc_output_format_timing_regs_bench;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        wr;
  logic        rd;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        rvalid;
  logic [11:0] sample = 12'h000;
  logic [2:0]  div = 3'h3;
  logic [3:0]  tmode = 4'h0;
  logic [11:0] d_out;
  logic        d_oe;
  logic        stb;
  logic        data_clock_out;
  logic [2:0]  cdc;
  logic        cde;
  logic [2:0]  ddc;
  logic        dde;
  logic [1:0]  dch;
  logic [1:0]  dcl;
  logic [1:0]  ddh;
  logic [1:0]  ddl;
  int          n_fail = 0;
  int          n_compared = 0;
  int          cycles = 0;
  int          master[256];
  int          active[256];
  int          regs[6] = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h19, 8'h1A};
  int          dly_tab[4] = '{8'hA5, 8'h83, 8'h27, 8'h00};

  always #50 ref_clk = ~ref_clk;

  ofr_host_model host (.ref_clk_i(ref_clk), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
    .reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));

  ofr_output_top dut (.ref_clk_i(ref_clk), .rst_i(rst), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .sample_i(sample), .clk_div_i(div), .test_mode_i(tmode), .data_o(d_out), .data_oe_o(d_oe),
    .sample_stb_o(stb), .data_clock_out_o(data_clock_out), .clk_dly_code_o(cdc), .clk_dly_en_o(cde),
    .data_dly_code_o(ddc), .data_dly_en_o(dde), .drive_clk_hi_o(dch), .drive_clk_lo_o(dcl),
    .drive_data_hi_o(ddh), .drive_data_lo_o(ddl));

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      n_fail++;
      close_out();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [11:0] enc(input logic [11:0] s, input int f, input int inv);
    logic [11:0] w;
    w = (f == 1) ? (s ^ 12'h800) : (f == 2) ? (s ^ (s >> 1)) : s;
    return (inv != 0) ? ~w : w;
  endfunction

  // true for the six mapped configuration addresses
  function automatic bit mapped(input logic [7:0] a);
    mapped = 1'b0;
    foreach (regs[j])
      if (regs[j] == int'(a))
        mapped = 1'b1;
  endfunction

  task automatic mwr(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d);
    if (mapped(a))
      master[a] = d;
    if (a == ofr_pkg::ADDR_TRANSFER && d[0])
      active = master;
  endtask

  task automatic mrd(input logic [7:0] a);
    logic [7:0] d;
    logic       v;
    host.rd(a, d, v);
    check("read valid", 16'(v), 16'h0001);
    check("read data", 16'(d), mapped(a) ? 16'(master[a]) : 16'h0000);
  endtask

  task automatic commit();
    mwr(ofr_pkg::ADDR_TRANSFER, 8'h01);
  endtask

  task automatic chk_cfg();
    int c;
    int f;
    c = active[8'h15];
    f = active[8'h17];
    repeat (2) @(posedge ref_clk);
    #1;
    check("drive clk hi", 16'(dch), 16'((c >> 6) & 3));
    check("drive clk lo", 16'(dcl), 16'((c >> 4) & 3));
    check("drive data hi", 16'(ddh), 16'((c >> 2) & 3));
    check("drive data lo", 16'(ddl), 16'(c & 3));
    check("clk dly en", 16'(cde), 16'((f >> 7) & 1));
    check("clk dly code", 16'(cdc), 16'(((f >> 7) & 1) * (f & 7)));
    check("data dly en", 16'(dde), 16'((f >> 5) & 1));
    check("data dly code", 16'(ddc), 16'(((f >> 5) & 1) * (f & 7)));
  endtask

  // four clock samples starting at a strobe, divider at four
  task automatic clk_shape(output logic [3:0] p);
    int k;
    k = 0;
    @(posedge ref_clk);
    #1;
    while (stb !== 1'b1 && k < 12)
    begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    for (k = 0; k < 4; k++)
    begin
      p[k] = data_clock_out;
      @(posedge ref_clk);
      #1;
    end
    check("strobe spacing", 16'(stb), 16'h0001);
  endtask

  initial
  begin
    logic [3:0]  p0;
    logic [3:0]  p;
    logic [3:0]  e;
    logic [11:0] s;
    int          i;
    int          k;
    foreach (master[j])
      master[j] = 0;
    master[8'h15] = ofr_pkg::RST_DRIVE;
    active = master;
    void'($urandom(4));
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (regs[j])
      mrd(8'(regs[j]));
    chk_cfg();
    clk_shape(p0);
    mwr(8'h16, 8'h83);
    mwr(ofr_pkg::ADDR_TRANSFER, 8'h00);
    mwr(8'h15, 8'($urandom));
    clk_shape(p);
    check("clock before transfer", 16'(p), 16'(p0));
    chk_cfg();
    for (i = 1; i < 16; i++)
    begin
      mwr(8'h16, 8'(((i / 8) << 7) | (i % 8)));
      commit();
      repeat (12) @(posedge ref_clk);
      clk_shape(p);
      for (k = 0; k < 4; k++)
        e[k] = p0[(k - i % 8 + 8) % 4] ^ 1'(i / 8);
      check("clock shape", 16'(p), 16'(e));
    end
    foreach (dly_tab[j])
    begin
      mwr(8'h17, 8'(dly_tab[j]));
      mwr(8'h15, 8'($urandom));
      commit();
      chk_cfg();
    end
    @(posedge ref_clk);
    div <= ofr_pkg::DIV_BY_1;
    for (i = 0; i < 6; i++)
    begin
      mwr(8'h14, 8'(((i % 2) << 4) | ((i / 3) << 2) | (i % 3)));
      commit();
      repeat (3) @(posedge ref_clk);
      for (k = 0; k < 4; k++)
      begin
        s = 12'($urandom);
        @(posedge ref_clk);
        sample <= s;
        @(posedge ref_clk);
        #1;
        check("data word", 16'(d_out), 16'(enc(s, i % 3, i / 3)));
        check("strobe", 16'(stb), 16'h0001);
        check("output disable", 16'(d_oe), 16'(i % 2));
      end
    end
    mwr(8'h19, 8'($urandom));
    mwr(8'h1A, 8'($urandom));
    commit();
    @(posedge ref_clk);
    tmode <= ofr_pkg::TEST_USER_INPUT;
    repeat (4) @(posedge ref_clk);
    #1;
    check("user pattern", 16'(d_out), 16'(((active[8'h1A] << 8) | active[8'h19]) >> 4));
    foreach (regs[j])
      mwr(8'(regs[j]), 8'($urandom));
    mwr(8'h18, 8'h5A);
    foreach (regs[j])
      mrd(8'(regs[j]));
    mrd(8'h18);
    mrd(ofr_pkg::ADDR_TRANSFER);
    close_out();
  end
endmodule
`default_nettype wire
